// [common/dms_led_if.sv]
// Status carried from the sequencer to the indicator encoder
`timescale 1ns/1ps
`default_nettype none
interface dms_led_if;
  logic maint;
  logic alarm;
  logic err;
  logic en;
  logic blink;
  modport seq (output maint, alarm, err, en, blink);
  modport led (input maint, alarm, err, en, blink);
endinterface
`default_nettype wire

// [common/dms_pkg.sv]
// Shared types, timing constants and helpers of the maintenance sequencer
package dms_pkg;

  typedef logic [16:0]        dms_sec_t;
  typedef logic [25:0]        dms_cyc_t;
  typedef logic signed [15:0] dms_dew_t;

  // -------------------------------------------------------------------
  // Timebase
  // -------------------------------------------------------------------
  localparam int unsigned CLK_NS  = 25;
  localparam int unsigned TICK_NS = 1_000_000_000;
  localparam dms_cyc_t    TICK_CYC = dms_cyc_t'(TICK_NS / CLK_NS);

  // -------------------------------------------------------------------
  // Sequence times in seconds
  // -------------------------------------------------------------------
  localparam dms_sec_t BOOT_S        = 17'h00002;
  localparam dms_sec_t PREMEAS_S     = 17'h00028;
  localparam dms_sec_t PURGE_S       = 17'h000b4;
  localparam dms_sec_t CAL_S         = 17'h00032;
  localparam dms_sec_t CAL_INT_S     = 17'h00e10;
  localparam dms_sec_t DRY_INT_S     = 17'h00258;
  localparam dms_sec_t PURGE_INT_S   = 17'h15180;
  localparam dms_sec_t STARTUP_MAX_S = 17'h0012c;
  localparam dms_sec_t LIVE_BY_S     = 17'h00168;
  localparam dms_sec_t SEC_ONE       = 17'h00001;
  localparam dms_sec_t SEC_ZERO      = 17'h00000;

  typedef enum logic [2:0] {
    ST_BOOT,
    ST_PREMEAS,
    ST_PURGE,
    ST_CAL,
    ST_RUN
  } dms_state_e;

  // True when one more second reaches the limit
  function automatic logic sec_hit(input dms_sec_t cnt,
                                   input dms_sec_t lim);
    return (cnt + SEC_ONE) >= lim;
  endfunction

  function automatic logic is_maint(input dms_state_e st);
    return (st == ST_PURGE) || (st == ST_CAL);
  endfunction

endpackage

// [dv/dms_elem_model.sv]
// Behavioural sensing element with heater that feeds the sequencer
`timescale 1ns/1ps
`default_nettype none
module dms_elem_model
  import dms_pkg::*;
(
  input  wire logic     clk_i,
  input  wire logic     heater_i,
  input  wire dms_dew_t base_dew_i,
  input  wire dms_dew_t gas_temp_i,
  output dms_dew_t      live_dew_o,
  output logic          risk_o,
  output logic          freezing_o,
  output logic          very_dry_o
);
  dms_dew_t drift_q = 16'sh0000;

  // -------------------------------------------------------------------
  // Heated polymer
  // -------------------------------------------------------------------
  // A heated element reads off the true value, so a leaky freeze shows
  always_ff @(posedge clk_i) begin
    if (heater_i) begin
      drift_q <= drift_q + 16'sh0007;
    end else begin
      drift_q <= 16'sh0000;
    end
  end

  // -------------------------------------------------------------------
  // Derived conditions
  // -------------------------------------------------------------------
  assign live_dew_o = base_dew_i + drift_q;
  assign risk_o     = (gas_temp_i - base_dew_i) < 16'sh0200;
  assign freezing_o = gas_temp_i < 16'sh0000;
  assign very_dry_o = base_dew_i < -16'sh1000;
endmodule
`default_nettype wire

// [dv/dms_seq_tb.sv]
// Self-checking testbench of the maintenance sequencer
`timescale 1ns/1ps
`default_nettype none
module dms_seq_tb;
  import dms_pkg::*;
  // Shortened seconds so a whole day fits in a few hundred cycles
  localparam int TK   = 4;
  localparam int BOOT = 2;
  localparam int PREM = 4;
  localparam int PRG  = 6;
  localparam int CAL  = 3;
  localparam int CINT = 20;
  localparam int DINT = 10;
  localparam int PINT = 60;

  logic     clk_i      = 1'b0;
  logic     rst_n_i    = 1'b0;
  logic     dew_change = 1'b0;
  logic     env_ok     = 1'b1;
  logic     err        = 1'b0;
  dms_dew_t lim        = 16'sh0000;
  logic     alarm_en   = 1'b0;
  logic     led_en     = 1'b1;
  dms_dew_t base_dew   = -16'sh0400;
  dms_dew_t gas_temp   = 16'sh0800;
  dms_dew_t live_dew;
  dms_dew_t dew_out;
  logic     very_dry;
  logic     risk;
  logic     freezing;
  logic     frozen;
  logic     heater;
  logic     warm;
  logic     cal_eval;
  logic     st_done;
  logic     green;
  logic     red;
  int       failures   = 0;
  int       n_compared = 0;

  always #12.5 clk_i = ~clk_i;

  dms_elem_model ELEM (
    .clk_i      (clk_i),
    .heater_i   (heater),
    .base_dew_i (base_dew),
    .gas_temp_i (gas_temp),
    .live_dew_o (live_dew),
    .risk_o     (risk),
    .freezing_o (freezing),
    .very_dry_o (very_dry)
  );

  dms_seq #(
    .TICK_C    (dms_cyc_t'(TK)),
    .BOOT_T    (dms_sec_t'(BOOT)),
    .PREMEAS_T (dms_sec_t'(PREM)),
    .PURGE_T   (dms_sec_t'(PRG)),
    .CAL_T     (dms_sec_t'(CAL)),
    .CAL_INT_T (dms_sec_t'(CINT)),
    .DRY_INT_T (dms_sec_t'(DINT)),
    .PRG_INT_T (dms_sec_t'(PINT))
  ) DUT (
    .clk_i           (clk_i),
    .rst_n_i         (rst_n_i),
    .live_dew_i      (live_dew),
    .very_dry_i      (very_dry),
    .dew_change_i    (dew_change),
    .env_ok_i        (env_ok),
    .dew_form_risk_i (risk),
    .freezing_i      (freezing),
    .error_i         (err),
    .alarm_limit_i   (lim),
    .alarm_en_i      (alarm_en),
    .led_en_i        (led_en),
    .dew_out_o       (dew_out),
    .frozen_o        (frozen),
    .heater_o        (heater),
    .warm_o          (warm),
    .cal_eval_o      (cal_eval),
    .startup_done_o  (st_done),
    .led_green_o     (green),
    .led_red_o       (red)
  );

  // -------------------------------------------------------------------
  // Helpers
  // -------------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] got,
                     input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %s expected %0h seen %0h", nm, exp, got);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  task automatic do_reset(input logic env, input dms_dew_t bd);
    @(posedge clk_i);
    rst_n_i  <= 1'b0;
    env_ok   <= env;
    base_dew <= bd;
    repeat (6) @(posedge clk_i);
    rst_n_i <= 1'b1;
    #1;
  endtask

  // Counts cycles until frozen_o rises, bounded
  task automatic wait_rise(input int max, output int n);
    n = 0;
    while (frozen !== 1'b1 && n < max) begin
      cyc(1);
      n++;
    end
  endtask

  // Runs through one maintenance window, watching output and indicator
  task automatic maint(output int len, output int nev);
    logic held;
    logic [3:0] seen;
    held = 1'b1;
    seen = 4'h0;
    len  = 0;
    nev  = 0;
    while (frozen === 1'b1 && len < 400) begin
      if (dew_out !== base_dew) held = 1'b0;
      if (green === 1'b0) seen[3] = 1'b1;
      if (green === 1'b1) seen[2] = 1'b1;
      if (red !== 1'b0) seen[1] = 1'b1;
      if (heater !== 1'b1) seen[0] = 1'b1;
      cyc(1);
      if (cal_eval === 1'b1) nev++;
      len++;
    end
    chk("dew_out held", held, 1'b1);
    chk("blink green heat", seen, 4'b1100);
    cyc(2);
    chk("dew_out live", dew_out, live_dew);
  endtask

  // Samples the indicator for 10 cycles: {g low, g high, r low, r high}
  task automatic led_look(input string nm, input logic [3:0] exp);
    logic [3:0] seen;
    seen = 4'h0;
    cyc(2);
    repeat (10) begin
      seen |= {green === 1'b0, green === 1'b1, red === 1'b0, red === 1'b1};
      cyc(1);
    end
    chk(nm, seen, exp);
  endtask

  // -------------------------------------------------------------------
  // Scenarios
  // -------------------------------------------------------------------
  task automatic t_schedule();
    int n;
    int len;
    int nev;
    int sk;
    do_reset(1'b1, -16'sh0400);
    wait_rise(60, n);
    chk("startup to purge", n >= (BOOT + PREM) * TK
        && n <= (BOOT + PREM) * TK + 6, 1'b1);
    maint(len, nev);
    chk("startup window", len, (PRG + CAL) * TK);
    chk("startup cal eval", nev, 1);
    chk("startup done", st_done, 1'b1);
    led_look("steady green", 4'b0110);
    sk = 14;
    repeat (2) begin
      wait_rise(120, n);
      chk("hourly gap", n >= (CINT - CAL) * TK - sk
          && n <= (CINT - CAL) * TK + 4 - sk, 1'b1);
      maint(len, nev);
      // Entry comes one cycle after a tick, so the first second is short
      chk("hourly cal len", len, CAL * TK - 1);
      sk = 2;
    end
    wait_rise(120, n);
    chk("daily purge gap", n >= (PINT - PRG - 2 * CINT - CAL) * TK - 2
        && n <= (PINT - PRG - 2 * CINT - CAL) * TK + 2, 1'b1);
    maint(len, nev);
    chk("purge heat len", len >= PRG * TK, 1'b1);
  endtask

  task automatic t_postpone();
    int n;
    int len;
    int nev;
    do_reset(1'b0, -16'sh0400);
    wait_rise(60, n);
    maint(len, nev);
    chk("purge only", len, PRG * TK);
    chk("live after purge", st_done, 1'b1);
    cyc(6);
    chk("cal refused", frozen, 1'b0);
    @(posedge clk_i);
    env_ok <= 1'b1;
    cyc(1);
    wait_rise(4, n);
    chk("deferred cal runs", frozen, 1'b1);
    maint(len, nev);
    // Entry lands two cycles ahead of a tick
    chk("deferred cal", {len[7:0], nev[3:0]},
        {8'((CAL - 1) * TK + 2), 4'h1});
  endtask

  task automatic t_dry_change();
    int n;
    int len;
    int nev;
    do_reset(1'b1, -16'sh1400);
    wait_rise(60, n);
    maint(len, nev);
    wait_rise(120, n);
    chk("dry gap", n >= (DINT - CAL) * TK - 4
        && n <= (DINT - CAL) * TK, 1'b1);
    maint(len, nev);
    @(posedge clk_i);
    dew_change <= 1'b1;
    @(posedge clk_i);
    dew_change <= 1'b0;
    cyc(1);
    wait_rise(4, n);
    chk("change starts cal", frozen, 1'b1);
    maint(len, nev);
    chk("change cal len", len, CAL * TK - 1);
  endtask

  task automatic t_warm_led();
    @(posedge clk_i);
    env_ok   <= 1'b0;
    base_dew <= -16'sh0100;
    gas_temp <= 16'sh0000;
    cyc(3);
    chk("warm on dew risk", {warm, frozen}, 2'b10);
    @(posedge clk_i);
    base_dew <= -16'sh0180;
    cyc(3);
    chk("live while warm", dew_out, -16'sh0180);
    @(posedge clk_i);
    base_dew <= -16'sh0300;
    gas_temp <= -16'sh0100;
    cyc(3);
    chk("warm in frost", warm, 1'b1);
    @(posedge clk_i);
    gas_temp <= 16'sh0800;
    cyc(3);
    chk("warm off", warm, 1'b0);
    @(posedge clk_i);
    led_en <= 1'b0;
    led_look("dark", 4'b1010);
    @(posedge clk_i);
    led_en   <= 1'b1;
    alarm_en <= 1'b1;
    lim      <= -16'sh0400;
    led_look("steady red", 4'b1001);
    @(posedge clk_i);
    err <= 1'b1;
    led_look("blink red", 4'b1011);
    @(posedge clk_i);
    err      <= 1'b0;
    alarm_en <= 1'b0;
    led_look("alarm off", 4'b0110);
  endtask

  // -------------------------------------------------------------------
  // Verdict
  // -------------------------------------------------------------------
  task automatic report_and_stop();
    if (failures == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk_i);
    failures++;
    report_and_stop();
  end

  initial begin
    t_schedule();
    t_postpone();
    t_dry_change();
    t_warm_led();
    report_and_stop();
  end
endmodule
`default_nettype wire

// [rtl/dms_led.sv]
// Status indicator encoder with fixed precedence
`timescale 1ns/1ps
`default_nettype none
module dms_led (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  dms_led_if.led    st,
  output logic      green_o,
  output logic      red_o
);
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      green_o <= 1'b0;
      red_o   <= 1'b0;
    end else if (!st.en) begin            // see RULE16
      green_o <= 1'b0;
      red_o   <= 1'b0;
    end else if (st.err) begin            // see RULE19 see RULE21
      green_o <= 1'b0;
      red_o   <= st.blink;
    end else if (st.maint) begin          // see RULE18 see RULE21
      green_o <= st.blink;
      red_o   <= 1'b0;
    end else if (st.alarm) begin          // see RULE19
      green_o <= 1'b0;
      red_o   <= 1'b1;
    end else begin                        // see RULE17
      green_o <= 1'b1;
      red_o   <= 1'b0;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  AST_LED_DARK: assert property (!st.en |=> !green_o && !red_o) // see RULE16
    else $error("Indicator lit while disabled");
  AST_LED_ERR: assert property ( // see RULE21
    st.en && st.err |=> !green_o && (red_o == $past(st.blink)))
    else $error("Error state not shown as blinking red");
  AST_LED_MAINT: assert property ( // see RULE18
    st.en && !st.err && st.maint |=> !red_o && green_o == $past(st.blink))
    else $error("Maintenance not shown as blinking green");
  AST_LED_ALARM: assert property ( // see RULE19
    st.en && !st.err && !st.maint && st.alarm |=> red_o && !green_o)
    else $error("Alarm not shown as steady red");
  AST_LED_NORMAL: assert property ( // see RULE17
    st.en && !st.err && !st.maint && !st.alarm |=> green_o && !red_o)
    else $error("Normal state not steady green");
endmodule
`default_nettype wire

// [rtl/dms_seq.sv]
// Maintenance sequencer: startup, calibration, purge, warming, indicator
//
// What this block does
// RULE1: Calibrate at power-on, then again every hour of operation.
// RULE2: Very dry gas shortens the calibration interval.
// RULE3: A large dewpoint or temperature change requests an extra calibration.
// RULE4: Calibration heats under a minute, then evaluates and corrects drift.
// RULE5: Calibration and purge publish the value held from before the cycle.
// RULE6: Calibration starts only when environment criteria hold; else deferred.
// RULE7: Purge at power-on, then every 24 hours of operation.
// RULE8: Purge keeps the element heated for several minutes.
// RULE9: Warming never freezes the live dewpoint output.
// RULE10: Warming switches on when dew could start to form.
// RULE11: In frost, warming keeps the element above zero degrees.
// RULE12: Two seconds startup, 40 seconds measuring, then purge and calibrate.
// RULE13: Startup purge plus calibration at most five minutes, output frozen.
// RULE14: Live output resumes within six minutes of power-up.
// RULE15: The startup sequence always runs and cannot be skipped.
// RULE16: Indicator dark when disabled by configuration.
// RULE17: Steady green while measuring normally.
// RULE18: Blinking green while purge or calibration runs.
// RULE19: Steady red above alarm limit, blinking red on internal error.
// RULE20: Host sets alarm limit, alarm enable and indicator enable.
// RULE21: Indicator precedence: error, maintenance, alarm, normal.
// RULE22: Postponed startup calibration: finish purge, go live, keep pending.
`timescale 1ns/1ps
`default_nettype none
module dms_seq
  import dms_pkg::*;
#(
  parameter dms_cyc_t TICK_C    = TICK_CYC,
  parameter dms_sec_t BOOT_T    = BOOT_S,
  parameter dms_sec_t PREMEAS_T = PREMEAS_S,
  parameter dms_sec_t PURGE_T   = PURGE_S,
  parameter dms_sec_t CAL_T     = CAL_S,
  parameter dms_sec_t CAL_INT_T = CAL_INT_S,
  parameter dms_sec_t DRY_INT_T = DRY_INT_S,
  parameter dms_sec_t PRG_INT_T = PURGE_INT_S
) (
  input  wire logic     clk_i,
  input  wire logic     rst_n_i,
  input  wire dms_dew_t live_dew_i,
  input  wire logic     very_dry_i,
  input  wire logic     dew_change_i,
  input  wire logic     env_ok_i,
  input  wire logic     dew_form_risk_i,
  input  wire logic     freezing_i,
  input  wire logic     error_i,
  input  wire dms_dew_t alarm_limit_i,
  input  wire logic     alarm_en_i,
  input  wire logic     led_en_i,
  output dms_dew_t      dew_out_o,
  output logic          frozen_o,
  output logic          heater_o,
  output logic          warm_o,
  output logic          cal_eval_o,
  output logic          startup_done_o,
  output logic          led_green_o,
  output logic          led_red_o
);

  // -------------------------------------------------------------------
  // Reset release
  // -------------------------------------------------------------------
  logic rst_meta_q;
  logic rst_sync_q;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  // -------------------------------------------------------------------
  // Timebase
  // -------------------------------------------------------------------
  logic tick;
  logic blink;

  dms_tick #(
    .CYC (TICK_C)
  ) u_tick (
    .clk_i   (clk_i),
    .rst_n_i (rst_sync_q),
    .tick_o  (tick),
    .blink_o (blink)
  );

  // -------------------------------------------------------------------
  // Sequence state
  // -------------------------------------------------------------------
  dms_state_e state_q;
  dms_state_e state_d;
  dms_sec_t   sec_q;
  dms_sec_t   cal_age_q;
  dms_sec_t   prg_age_q;
  dms_sec_t   up_sec_q;
  dms_sec_t   cal_int;
  logic       cal_pend_q;
  logic       prg_pend_q;
  logic       cal_go;
  logic       cal_due;
  logic       prg_due;

  assign cal_go  = cal_pend_q && env_ok_i;                  // see RULE6
  assign cal_int = very_dry_i ? DRY_INT_T : CAL_INT_T;      // see RULE2
  assign cal_due = tick && sec_hit(cal_age_q, cal_int);     // see RULE1
  assign prg_due = tick && sec_hit(prg_age_q, PRG_INT_T);   // see RULE7

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_BOOT: begin
        if (tick && sec_hit(sec_q, BOOT_T)) begin         // see RULE12
          state_d = ST_PREMEAS;
        end
      end
      ST_PREMEAS: begin
        if (tick && sec_hit(sec_q, PREMEAS_T)) begin      // see RULE12
          state_d = ST_PURGE;
        end
      end
      ST_PURGE: begin
        // A schedule request on the last tick goes straight on, so the
        // output is not released for a single heated sample
        if (tick && sec_hit(sec_q, PURGE_T)) begin        // see RULE8
          state_d = (cal_go || (cal_due && env_ok_i)) ?  // see RULE5
                    ST_CAL : ST_RUN;                      // see RULE22
        end
      end
      ST_CAL: begin
        if (tick && sec_hit(sec_q, CAL_T)) begin          // see RULE4
          state_d = ST_RUN;
        end
      end
      ST_RUN: begin
        if (prg_pend_q) begin                             // see RULE7
          state_d = ST_PURGE;
        end else if (cal_go) begin                        // see RULE6
          state_d = ST_CAL;
        end
      end
      default: begin
        state_d = ST_BOOT;
      end
    endcase
  end

  // No bypass input exists: every reset restarts at boot
  always_ff @(posedge clk_i or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      state_q <= ST_BOOT;                                 // see RULE15
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge clk_i or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      sec_q <= SEC_ZERO;
    end else if (state_d != state_q) begin
      sec_q <= SEC_ZERO;
    end else if (tick) begin
      sec_q <= sec_q + SEC_ONE;
    end
  end

  // -------------------------------------------------------------------
  // Schedules and pending requests
  // -------------------------------------------------------------------
  // Age stops one second short of the interval so a deferred request does not wrap
  always_ff @(posedge clk_i or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      cal_age_q <= SEC_ZERO;
    end else if (state_q != ST_CAL && state_d == ST_CAL) begin
      cal_age_q <= SEC_ZERO;
    end else if (tick && !sec_hit(cal_age_q, cal_int)) begin
      cal_age_q <= cal_age_q + SEC_ONE;
    end
  end

  always_ff @(posedge clk_i or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      prg_age_q <= SEC_ZERO;
    end else if (state_q != ST_PURGE && state_d == ST_PURGE) begin
      prg_age_q <= SEC_ZERO;
    end else if (tick && !sec_hit(prg_age_q, PRG_INT_T)) begin
      prg_age_q <= prg_age_q + SEC_ONE;
    end
  end

  // Power-on calibration is pending from reset. A change event wins
  // over the clear on entry; a schedule request on that edge is the
  // one being served, else a saturated age would queue a second run
  always_ff @(posedge clk_i or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      cal_pend_q <= 1'b1;                                 // see RULE1
    end else if (dew_change_i) begin                      // see RULE3
      cal_pend_q <= 1'b1;
    end else if (state_q != ST_CAL && state_d == ST_CAL) begin
      cal_pend_q <= 1'b0;
    end else if (cal_due) begin                           // see RULE1
      cal_pend_q <= 1'b1;
    end
  end

  // The startup purge comes from the sequence itself
  always_ff @(posedge clk_i or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      prg_pend_q <= 1'b0;
    end else if (prg_due) begin                           // see RULE7
      prg_pend_q <= 1'b1;
    end else if (state_q != ST_PURGE && state_d == ST_PURGE) begin
      prg_pend_q <= 1'b0;
    end
  end

  // -------------------------------------------------------------------
  // Outputs toward the element and the measurement path
  // -------------------------------------------------------------------
  // Holding the last published word avoids a separate capture register
  always_ff @(posedge clk_i or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      dew_out_o <= '0;
      frozen_o  <= 1'b0;
    end else begin
      frozen_o  <= is_maint(state_d);                     // see RULE13
      if (!is_maint(state_d)) begin                       // see RULE5
        dew_out_o <= live_dew_i;                          // see RULE9
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      heater_o <= 1'b0;
    end else begin
      heater_o <= is_maint(state_d);                      // see RULE4
    end
  end

  // Warming only adds heat; it is not a maintenance state
  always_ff @(posedge clk_i or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      warm_o <= 1'b0;
    end else begin
      warm_o <= (state_d != ST_BOOT) &&
                (dew_form_risk_i ||                       // see RULE10
                 freezing_i);                             // see RULE11
    end
  end

  // Drift evaluation happens at the end of the heated phase
  always_ff @(posedge clk_i or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      cal_eval_o <= 1'b0;
    end else begin
      cal_eval_o <= (state_q == ST_CAL) && (state_d == ST_RUN); // see RULE4
    end
  end

  always_ff @(posedge clk_i or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      startup_done_o <= 1'b0;
    end else if (state_d == ST_RUN) begin                 // see RULE14
      startup_done_o <= 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      up_sec_q <= SEC_ZERO;
    end else if (tick && !startup_done_o) begin
      up_sec_q <= up_sec_q + SEC_ONE;
    end
  end

  // -------------------------------------------------------------------
  // Indicator
  // -------------------------------------------------------------------
  dms_led_if led_bus ();

  assign led_bus.maint = frozen_o;
  assign led_bus.alarm = alarm_en_i &&                    // see RULE20
                         (dew_out_o > alarm_limit_i);
  assign led_bus.err   = error_i;
  assign led_bus.en    = led_en_i;                        // see RULE20
  assign led_bus.blink = blink;

  dms_led u_led (
    .clk_i   (clk_i),
    .rst_n_i (rst_sync_q),
    .st      (led_bus.led),
    .green_o (led_green_o),
    .red_o   (led_red_o)
  );

  // -------------------------------------------------------------------
  // Checks
  // -------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_sync_q);

  AST_FREEZE_HOLD: assert property ( // see RULE5
    frozen_o && $past(frozen_o) |-> $stable(dew_out_o))
    else $error("Published value moved while frozen");
  AST_LIVE_FOLLOW: assert property ( // see RULE9
    !frozen_o && $past(state_d) == ST_RUN |-> dew_out_o == $past(live_dew_i))
    else $error("Live output not following measurement");
  AST_WARM_DEW: assert property ( // see RULE10
    state_q == ST_RUN && dew_form_risk_i |=> warm_o)
    else $error("Warming not on near dew formation");
  AST_WARM_FROST: assert property ( // see RULE11
    state_q != ST_BOOT && freezing_i |=> warm_o)
    else $error("Warming not on in frost");
  AST_CAL_SHORT: assert property ( // see RULE4
    state_q == ST_CAL |-> sec_q < CAL_T && heater_o)
    else $error("Calibration heating too long or heater off");
  AST_CAL_ENV: assert property ( // see RULE6
    state_q != ST_CAL ##1 state_q == ST_CAL |-> $past(env_ok_i))
    else $error("Calibration began with criteria unmet");
  AST_BOOT_ORDER: assert property ( // see RULE15
    $past(state_q) == ST_BOOT && state_q != ST_BOOT |-> state_q == ST_PREMEAS)
    else $error("Startup step skipped");
  AST_BOOT_TIME: assert property ( // see RULE12
    state_q == ST_PREMEAS && $past(state_q) == ST_BOOT |-> up_sec_q == BOOT_T)
    else $error("Startup phase length wrong");
  AST_PREMEAS_EXIT: assert property ( // see RULE12
    state_q == ST_PREMEAS && state_d != ST_PREMEAS |-> state_d == ST_PURGE)
    else $error("Measuring phase not followed by purge");
  AST_DRY_REQ: assert property ( // see RULE2
    very_dry_i && tick && sec_hit(cal_age_q, DRY_INT_T) |=>
      cal_pend_q || (state_q == ST_CAL && $past(state_q) != ST_CAL))
    else $error("Dry interval did not request calibration");
  AST_PURGE_REQ: assert property ( // see RULE7
    prg_due |=> prg_pend_q)
    else $error("Daily purge not requested");
  AST_STARTUP_MAX: assert property ( // see RULE13
    !startup_done_o && is_maint(state_q) |->
      up_sec_q < BOOT_T + PREMEAS_T + STARTUP_MAX_S)
    else $error("Startup maintenance too long");
  AST_LIVE_BY: assert property ( // see RULE14
    up_sec_q >= LIVE_BY_S |-> startup_done_o)
    else $error("Live output not resumed in time");
  AST_KEEP_PEND: assert property ( // see RULE22
    $past(state_q == ST_PURGE && cal_pend_q) && state_q == ST_RUN
      |-> cal_pend_q)
    else $error("Deferred calibration request lost");

  COV_CAL_RUN: cover property (state_q == ST_CAL ##1 state_q == ST_RUN);
  COV_POSTPONE: cover property (
    state_q == ST_PURGE ##1 state_q == ST_RUN && cal_pend_q);
  COV_DAILY_PURGE: cover property (
    startup_done_o && state_q == ST_RUN ##1 state_q == ST_PURGE);
  COV_WARM_LIVE: cover property (warm_o && !frozen_o);

endmodule
`default_nettype wire

// [rtl/dms_tick.sv]
// One-second tick and blink phase generator
`timescale 1ns/1ps
`default_nettype none
module dms_tick
  import dms_pkg::*;
#(
  parameter dms_cyc_t CYC = TICK_CYC
) (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  output logic      tick_o,
  output logic      blink_o
);
  dms_cyc_t pre_q;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pre_q  <= '0;
      tick_o <= 1'b0;
    end else if (pre_q == CYC - dms_cyc_t'(1)) begin
      pre_q  <= '0;
      tick_o <= 1'b1;
    end else begin
      pre_q  <= pre_q + dms_cyc_t'(1);
      tick_o <= 1'b0;
    end
  end

  // Blink phase flips once a second
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      blink_o <= 1'b0;
    end else if (tick_o) begin
      blink_o <= ~blink_o;
    end
  end
endmodule
`default_nettype wire
